// ==== design/aop_chan_path.sv ====
`timescale 1ns/100ps
module aop_chan_path (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Sample and settings
  input wire logic [aop_pkg::SAMP_W-1:0] sample_in,
  input wire logic [aop_pkg::OFF_W-1:0] offset_in,
  input wire logic offset_en_in,
  input wire logic hpf_en_in,
  input wire logic [aop_pkg::K_W-1:0] hpf_k_in,
  input wire logic [aop_pkg::CODE_W-1:0] gain_code_in,
  input wire logic gain_en_in,
  // Result
  output logic [aop_pkg::SAMP_W-1:0] result_out
);
  import aop_pkg::*;
  localparam int IW = SAMP_W + 4;
  localparam int PW = SAMP_W + 13;
  localparam logic signed [IW-1:0] MAXV = IW'(2 ** (SAMP_W - 1) - 1);
  localparam logic signed [IW-1:0] MINV = IW'(-(2 ** (SAMP_W - 1)));

  function automatic logic [SAMP_W-1:0] sat(input logic signed [IW-1:0] v);
    if (v > MAXV) sat = MAXV[SAMP_W-1:0];
    else if (v < MINV) sat = MINV[SAMP_W-1:0];
    else sat = v[SAMP_W-1:0];
  endfunction

  function automatic logic [11:0] gain_mult(input logic [CODE_W-1:0] c);
    logic [11:0] t [31];
    t = '{12'h400, 12'h418, 12'h430, 12'h449, 12'h463, 12'h47D, 12'h498,
      12'h4B3, 12'h4CF, 12'h4EC, 12'h509, 12'h527, 12'h546, 12'h565,
      12'h585, 12'h5A6, 12'h5C8, 12'h5EA, 12'h60E, 12'h632, 12'h657,
      12'h67C, 12'h6A3, 12'h6CB, 12'h6F3, 12'h71D, 12'h747, 12'h772,
      12'h79F, 12'h7CC, 12'h7FB};
    gain_mult = t[(c > GAIN_MAX_CODE) ? GAIN_MAX_CODE : c]; // [RULE_05]
  endfunction

  logic [SAMP_W-1:0] x_q, h_q;
  logic signed [IW-1:0] xp_q, yp_q;

  // Offset in two's complement, a negative code adds
  wire signed [IW-1:0] samp_w = IW'(signed'(sample_in));
  wire signed [IW-1:0] off_w = offset_en_in ? IW'(signed'(offset_in)) : '0;
  wire signed [IW-1:0] x_w = IW'(signed'(x_q));
  // Gain of 2^k/(2^k+1) taken as 1 - 2^-k + 2^-2k
  wire signed [IW-1:0] z_w = x_w - xp_q + yp_q;
  wire [LEN_W-1:0] k2_w = LEN_W'({hpf_k_in, 1'b0});
  wire signed [IW-1:0] y_w = z_w - (z_w >>> hpf_k_in) + (z_w >>> k2_w);
  wire signed [PW-1:0] prod_w =
    signed'(h_q) * signed'({1'b0, gain_mult(gain_code_in)});
  wire signed [IW-1:0] scaled_w = IW'(prod_w >>> GAIN_FRAC);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      x_q <= '0;
      h_q <= '0;
      xp_q <= '0;
      yp_q <= '0;
      result_out <= '0;
    end else begin
      x_q <= sat(samp_w - off_w); // [RULE_13] [RULE_14]
      h_q <= hpf_en_in ? sat(y_w) : x_q; // [RULE_06] [RULE_07]
      xp_q <= x_w;
      yp_q <= hpf_en_in ? IW'(signed'(sat(y_w))) : '0;
      result_out <= gain_en_in ? sat(scaled_w) : h_q; // [RULE_04] [RULE_15]
    end
  end
endmodule

// ==== design/aop_pkg.sv ====
package aop_pkg;
  // Geometry
  localparam int CH = 8;
  localparam int SAMP_W = 14;
  localparam int OFF_W = 10;
  localparam int CODE_W = 5;
  localparam int K_W = 4;
  localparam int LANE_W = 32;
  localparam int LEN_W = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int REG_COUNT = 34;
  localparam int REG_IDX_W = 6;
  localparam logic [4:0] SPI_LAST_BIT = 5'h17;
  localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_RATE = 8'h01;
  localparam logic [ADDR_W-1:0] REG_AVG_PAT = 8'h02;
  localparam logic [ADDR_W-1:0] REG_OGW = 8'h03;
  localparam logic [ADDR_W-1:0] REG_FMT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CUST = 8'h05;
  localparam logic [ADDR_W-1:0] REG_PSYNC = 8'h0A;
  localparam logic [ADDR_W-1:0] REG_HPF_LO = 8'h15;
  localparam logic [ADDR_W-1:0] REG_HPF_HI = 8'h21;
  // Per-channel offset and scale code registers, channel 1 first
  localparam logic [ADDR_W-1:0] CHAN_REG [CH] = '{8'h0D, 8'h0F, 8'h11,
    8'h13, 8'h1F, 8'h1D, 8'h1B, 8'h19};
  // Field positions
  localparam int BIT_SHARED = 14;
  localparam int BIT_AVG = 11;
  localparam int PAT_HI = 15;
  localparam int PAT_LO = 13;
  localparam int BIT_GAIN_EN = 12;
  localparam int BIT_OFF_EN = 8;
  localparam int RATE_HI = 14;
  localparam int RATE_LO = 13;
  localparam int BIT_FMT = 3;
  localparam int FMT_RATE_HI = 2;
  localparam int BIT_PSYNC = 8;
  localparam int BIT_HPF_EN = 0;
  localparam int K_HI = 4;
  localparam int K_LO = 1;
  localparam int OFF_HI = 9;
  localparam int GAIN_HI = 15;
  localparam int GAIN_LO = 11;
  localparam int CUST_HI = 13;
  // Pattern selects
  localparam logic [2:0] PAT_NONE = 3'h0;
  localparam logic [2:0] PAT_SYNC = 3'h1;
  localparam logic [2:0] PAT_DESKEW = 3'h2;
  localparam logic [2:0] PAT_CUSTOM = 3'h3;
  localparam logic [2:0] PAT_ONES = 3'h4;
  localparam logic [2:0] PAT_TOGGLE = 3'h5;
  localparam logic [2:0] PAT_ZEROS = 3'h6;
  localparam logic [2:0] PAT_RAMP = 3'h7;
  localparam logic [SAMP_W-1:0] DESKEW_WORD = 14'h1555;
  localparam logic [SAMP_W-1:0] SYNC_WORD = 14'h3F80;
  // Word length selects
  localparam logic [1:0] RATE_12 = 2'h3;
  localparam logic [1:0] RATE_16 = 2'h1;
  localparam logic [2:0] FMT_RATE_12 = 3'h2;
  localparam logic [2:0] FMT_RATE_STD = 3'h0;
  localparam logic [LEN_W-1:0] LEN_12 = 6'h0C;
  localparam logic [LEN_W-1:0] LEN_14 = 6'h0E;
  localparam logic [LEN_W-1:0] LEN_16 = 6'h10;
  // Scale
  localparam logic [CODE_W-1:0] GAIN_MAX_CODE = 5'h1E;
  localparam int GAIN_FRAC = 10;
endpackage

// ==== design/aop_serializer.sv ====
`timescale 1ns/100ps
module aop_serializer #(
  parameter int LANES = 8,
  parameter int LANE_W = 32,
  parameter int LEN_W = 6
) (
  // Link clock and reset
  input wire logic bit_clk_in,
  input wire logic rst_b_in,
  // Word handshake from the sample clock side
  input wire logic req_in,
  input wire logic [LANES*LANE_W-1:0] bundle_in,
  input wire logic [LEN_W-1:0] len_in,
  output logic ack_out,
  // Double data rate lanes
  output logic [LANES-1:0] rise_out,
  output logic [LANES-1:0] fall_out,
  output logic frame_out
);
  logic [1:0] rst_sync_q;
  logic [1:0] req_sync_q;
  logic [LANE_W-1:0] sh_q [LANES];
  logic [LEN_W-1:0] cnt_q;
  wire lrst_b = rst_sync_q[1];
  wire busy_w = cnt_q != '0;
  // A new word waits until the previous one has left the lanes
  wire take_w = (req_sync_q[1] ^ ack_out) & ~busy_w;

  always_ff @(posedge bit_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rst_sync_q <= '0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  always_ff @(posedge bit_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      req_sync_q <= '0;
      ack_out <= 1'b0;
      cnt_q <= '0;
      frame_out <= 1'b0;
      rise_out <= '0;
      fall_out <= '0;
      for (int i = 0; i < LANES; i++) sh_q[i] <= '0;
    end else begin
      req_sync_q <= {req_sync_q[0], req_in};
      frame_out <= take_w;
      if (take_w) begin
        ack_out <= req_sync_q[1];
        cnt_q <= len_in;
        for (int i = 0; i < LANES; i++) begin
          sh_q[i] <= bundle_in[i*LANE_W +: LANE_W];
        end
      end else if (busy_w) begin
        cnt_q <= cnt_q - LEN_W'(2);
        for (int i = 0; i < LANES; i++) begin
          sh_q[i] <= {sh_q[i][LANE_W-3:0], 2'b00};
        end
      end
      // Two distinct bits per link cycle, one per edge
      for (int i = 0; i < LANES; i++) begin
        rise_out[i] <= busy_w & sh_q[i][LANE_W-1]; // [RULE_09]
        fall_out[i] <= busy_w & sh_q[i][LANE_W-2]; // [RULE_09]
      end
    end
  end

  a_lane_idle_zero: assert property ( // [RULE_09]
    @(posedge bit_clk_in) disable iff (!lrst_b)
    !busy_w |=> rise_out == '0 && fall_out == '0)
    else $error("lane bits driven while idle");
endmodule

// ==== design/aop_top.sv ====
`timescale 1ns/100ps
// How it works
// RULE_01 - Averaging bit averages channel pairs
// RULE_02 - Pair averages go to lanes three to six
// RULE_03 - Format bit inverts MSB for offset binary
// RULE_04 - Gain enable scales by 0.2 dB steps
// RULE_05 - Code 31 acts as code 30
// RULE_06 - Per-group first order high-pass filter
// RULE_07 - One filter coefficient per four channels
// RULE_08 - Host keeps coefficient between 2 and 10
// RULE_09 - Serial data on both clock edges
// RULE_10 - Shared mode puts two channels per lane
// RULE_11 - Unused lanes send zero in shared mode
// RULE_12 - Shared lanes three to six, lower first
// RULE_13 - Offset enable subtracts per-channel offset
// RULE_14 - Offset is a two's complement value
// RULE_15 - Offset, then gain, format conversion last
// RULE_16 - Rate fields pick 12, 14, 16 bits
// RULE_17 - Nonzero select replaces data with pattern
// RULE_18 - Ramp pattern steps one code per cycle
// RULE_19 - Selects for all zeros and all ones
// RULE_20 - Deskew select sends alternating bit word
// RULE_21 - Sync select sends fixed sync word
// RULE_22 - Toggle select alternates ones and zeros
// RULE_23 - Custom select sends written pattern value
// RULE_24 - Pattern sync starts all ramps together
module aop_top (
  // System
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Serial configuration port
  input wire logic sclk_in,
  input wire logic sen_b_in,
  input wire logic sdata_in,
  output logic sdout_out,
  // Converter samples, channel 1 in the low bits
  input wire logic [aop_pkg::CH*aop_pkg::SAMP_W-1:0] adc_data_in,
  // Serial output link
  input wire logic bit_clk_in,
  output logic [aop_pkg::CH-1:0] lane_rise_out,
  output logic [aop_pkg::CH-1:0] lane_fall_out,
  output logic frame_out
);
  import aop_pkg::*;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = 1'b0;
    if (a == REG_RATE || a == REG_AVG_PAT || a == REG_OGW) mapped = 1'b1;
    if (a == REG_FMT || a == REG_CUST || a == REG_PSYNC) mapped = 1'b1;
    if (a == REG_HPF_LO || a == REG_HPF_HI) mapped = 1'b1;
    for (int i = 0; i < CH; i++) begin
      if (a == CHAN_REG[i]) mapped = 1'b1;
    end
  endfunction

  function automatic logic [SAMP_W-1:0] avg2(input logic [SAMP_W-1:0] a,
                                              input logic [SAMP_W-1:0] b);
    logic signed [SAMP_W:0] s;
    s = (SAMP_W + 1)'(signed'(a)) + (SAMP_W + 1)'(signed'(b));
    avg2 = s[SAMP_W:1];
  endfunction

  function automatic logic [LANE_W-1:0] fit(input logic [SAMP_W-1:0] w,
                                            input logic [LEN_W-1:0] len);
    case (len)
      LEN_12: fit = {w[SAMP_W-1:2], 20'h00000};
      LEN_16: fit = {w, 2'b00, 16'h0000};
      default: fit = {w, 18'h00000};
    endcase
  endfunction

  // Serial port synchronisers and shifter
  logic [2:0] sclk_sync_q;
  logic [1:0] sen_sync_q;
  logic [1:0] sdi_sync_q;
  logic [4:0] bit_cnt_q;
  logic [22:0] shift_q;
  logic [DATA_W-1:0] rd_shift_q;
  logic [DATA_W-1:0] regs_q [REG_COUNT];

  wire sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  wire spi_sel = ~sen_sync_q[1];
  wire spi_bit = spi_sel & sclk_rise;
  wire spi_last = spi_bit & (bit_cnt_q == SPI_LAST_BIT);
  wire spi_addr_done = spi_bit & (bit_cnt_q == SPI_ADDR_LAST);
  wire [23:0] spi_word = {shift_q, sdi_sync_q[1]};
  wire [ADDR_W-1:0] wr_addr = spi_word[23:16];
  wire [DATA_W-1:0] wr_data = spi_word[15:0];
  wire [ADDR_W-1:0] rd_addr = {shift_q[6:0], sdi_sync_q[1]};
  wire [DATA_W-1:0] rd_data = mapped(rd_addr) ?
    regs_q[rd_addr[REG_IDX_W-1:0]] : REG_RESET;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_sync_q <= '0;
      sen_sync_q <= 2'b11;
      sdi_sync_q <= '0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
      sen_sync_q <= {sen_sync_q[0], sen_b_in};
      sdi_sync_q <= {sdi_sync_q[0], sdata_in};
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
      rd_shift_q <= '0;
    end else if (!spi_sel) begin
      bit_cnt_q <= '0;
    end else if (spi_bit) begin
      bit_cnt_q <= spi_last ? 5'h00 : bit_cnt_q + 5'h01;
      shift_q <= {shift_q[21:0], sdi_sync_q[1]};
      rd_shift_q <= spi_addr_done ? rd_data : {rd_shift_q[DATA_W-2:0], 1'b0};
    end
  end

  assign sdout_out = rd_shift_q[DATA_W-1];

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < REG_COUNT; i++) regs_q[i] <= REG_RESET;
    end else if (spi_last && mapped(wr_addr)) begin
      regs_q[wr_addr[REG_IDX_W-1:0]] <= wr_data;
    end
  end

  // Configuration fields
  wire [DATA_W-1:0] r_rate = regs_q[REG_RATE[REG_IDX_W-1:0]];
  wire [DATA_W-1:0] r_avg = regs_q[REG_AVG_PAT[REG_IDX_W-1:0]];
  wire [DATA_W-1:0] r_ogw = regs_q[REG_OGW[REG_IDX_W-1:0]];
  wire [DATA_W-1:0] r_fmt = regs_q[REG_FMT[REG_IDX_W-1:0]];
  wire [DATA_W-1:0] r_cust = regs_q[REG_CUST[REG_IDX_W-1:0]];
  wire [DATA_W-1:0] r_psync = regs_q[REG_PSYNC[REG_IDX_W-1:0]];
  wire [DATA_W-1:0] r_hpf_lo = regs_q[REG_HPF_LO[REG_IDX_W-1:0]];
  wire [DATA_W-1:0] r_hpf_hi = regs_q[REG_HPF_HI[REG_IDX_W-1:0]];
  wire shared_lane_mode = r_rate[BIT_SHARED];
  wire avg_on = r_avg[BIT_AVG];
  wire [2:0] pat_sel = r_avg[PAT_HI:PAT_LO];
  wire gain_on = r_ogw[BIT_GAIN_EN];
  wire offset_on = r_ogw[BIT_OFF_EN];
  wire [1:0] rate_hi = r_ogw[RATE_HI:RATE_LO];
  wire [2:0] rate_lo = r_fmt[FMT_RATE_HI:0];
  wire offset_binary = r_fmt[BIT_FMT];
  wire pat_sync_on = r_psync[BIT_PSYNC];

  // Word length from the two rate fields
  wire [LEN_W-1:0] word_length_select =
    (rate_hi == RATE_12 && rate_lo == FMT_RATE_12) ? LEN_12 : // [RULE_16]
    (rate_hi == RATE_16 && rate_lo == FMT_RATE_STD) ? LEN_16 : LEN_14;

  // Test pattern sources
  logic [SAMP_W-1:0] ramp_q;
  logic toggle_q;
  logic psync_prev_q;
  logic [SAMP_W-1:0] cust_q;
  wire psync_rise = pat_sync_on & ~psync_prev_q;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ramp_q <= '0;
      toggle_q <= 1'b0;
      psync_prev_q <= 1'b0;
      cust_q <= '0;
    end else begin
      ramp_q <= psync_rise ? '0 : ramp_q + SAMP_W'(1); // [RULE_18] [RULE_24]
      toggle_q <= ~toggle_q; // [RULE_22]
      psync_prev_q <= pat_sync_on;
      cust_q <= r_cust[CUST_HI:0]; // [RULE_23]
    end
  end

  logic [SAMP_W-1:0] pat_word;
  always_comb begin
    case (pat_sel)
      PAT_RAMP: pat_word = ramp_q; // [RULE_18]
      PAT_ZEROS: pat_word = '0; // [RULE_19]
      PAT_ONES: pat_word = '1; // [RULE_19]
      PAT_DESKEW: pat_word = DESKEW_WORD; // [RULE_20]
      PAT_SYNC: pat_word = SYNC_WORD; // [RULE_21]
      PAT_TOGGLE: pat_word = {SAMP_W{toggle_q}}; // [RULE_22]
      PAT_CUSTOM: pat_word = cust_q; // [RULE_23]
      default: pat_word = '0;
    endcase
  end
  wire pat_on = pat_sel != PAT_NONE;

  // Per-channel arithmetic
  logic [SAMP_W-1:0] proc_w [CH];
  logic [SAMP_W-1:0] chan_val [CH];
  logic [LANE_W-1:0] lane_w [CH];
  for (genvar c = 0; c < CH; c++) begin : g_chan
    wire [DATA_W-1:0] r_ch = regs_q[CHAN_REG[c][REG_IDX_W-1:0]];
    wire [DATA_W-1:0] r_hpf = (c < CH / 2) ? r_hpf_lo : r_hpf_hi;
    aop_chan_path u_path (
      .clk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .sample_in(adc_data_in[c*SAMP_W +: SAMP_W]),
      .offset_in(r_ch[OFF_HI:0]),
      .offset_en_in(offset_on),
      .hpf_en_in(r_hpf[BIT_HPF_EN]),
      .hpf_k_in(r_hpf[K_HI:K_LO]),
      .gain_code_in(r_ch[GAIN_HI:GAIN_LO]),
      .gain_en_in(gain_on),
      .result_out(proc_w[c])
    );
    // Pattern replaces data; format applied to data at the very end
    assign chan_val[c] = pat_on ? pat_word : // [RULE_17]
      {proc_w[c][SAMP_W-1] ^ offset_binary, // [RULE_03]
       proc_w[c][SAMP_W-2:0]};
  end

  // Lane routing
  for (genvar l = 0; l < CH; l++) begin : g_lane
    if (l >= 2 && l <= 5) begin : g_used
      localparam int P = 2 * (l - 2);
      wire [SAMP_W-1:0] avg_raw = avg2(proc_w[P], proc_w[P+1]); // [RULE_01]
      wire [SAMP_W-1:0] avg_val = pat_on ? pat_word :
        {avg_raw[SAMP_W-1] ^ offset_binary, avg_raw[SAMP_W-2:0]};
      wire [LANE_W-1:0] pair_w = fit(chan_val[P], word_length_select) |
        (fit(chan_val[P+1], word_length_select) >> word_length_select);
      assign lane_w[l] = shared_lane_mode ? pair_w : // [RULE_10] [RULE_12]
        avg_on ? fit(avg_val, word_length_select) : // [RULE_02]
        fit(chan_val[l], word_length_select);
    end else begin : g_spare
      assign lane_w[l] = (shared_lane_mode || avg_on) ? '0 : // [RULE_11]
        fit(chan_val[l], word_length_select);
    end
  end

  wire [LEN_W-1:0] lane_len = shared_lane_mode ?
    LEN_W'({word_length_select, 1'b0}) : word_length_select;

  // Crossing into the link domain by request and acknowledge toggles
  logic [CH*LANE_W-1:0] bundle_q;
  logic [LEN_W-1:0] len_q;
  logic req_q;
  logic [1:0] ack_sync_q;
  logic ack_w;
  wire load_w = req_q == ack_sync_q[1];

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bundle_q <= '0;
      len_q <= LEN_14;
      req_q <= 1'b0;
      ack_sync_q <= '0;
    end else begin
      ack_sync_q <= {ack_sync_q[0], ack_w};
      if (load_w) begin
        for (int i = 0; i < CH; i++) bundle_q[i*LANE_W +: LANE_W] <= lane_w[i];
        len_q <= lane_len;
        req_q <= ~req_q;
      end
    end
  end

  aop_serializer #(
    .LANES(CH),
    .LANE_W(LANE_W),
    .LEN_W(LEN_W)
  ) u_ser (
    .bit_clk_in(bit_clk_in),
    .rst_b_in(rst_b_in),
    .req_in(req_q),
    .bundle_in(bundle_q),
    .len_in(len_q),
    .ack_out(ack_w),
    .rise_out(lane_rise_out),
    .fall_out(lane_fall_out),
    .frame_out(frame_out)
  );

  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  wire plain_w = !pat_on && !shared_lane_mode;

  a_avg_pair_math: assert property ( // [RULE_01]
    plain_w && avg_on && !offset_binary && word_length_select == LEN_14
    |-> lane_w[2][31:18] == avg2(proc_w[0], proc_w[1]) &&
        lane_w[5][31:18] == avg2(proc_w[6], proc_w[7]))
    else $error("pair average wrong or misrouted");

  a_avg_spare_zero: assert property ( // [RULE_02]
    avg_on && !shared_lane_mode |-> lane_w[0] == '0 && lane_w[7] == '0)
    else $error("spare lane not zero in averaging");

  a_format_msb: assert property ( // [RULE_03]
    plain_w && !avg_on && offset_binary && word_length_select != LEN_12 |->
    lane_w[0][31] == ~proc_w[0][SAMP_W-1] &&
    lane_w[0][30:18] == proc_w[0][SAMP_W-2:0])
    else $error("offset binary conversion wrong");

  a_idle_lanes_zero: assert property ( // [RULE_11]
    shared_lane_mode |-> lane_w[0] == '0 && lane_w[1] == '0 &&
    lane_w[6] == '0 && lane_w[7] == '0)
    else $error("unused lane carries data");

  a_shared_order: assert property ( // [RULE_12]
    shared_lane_mode && word_length_select == LEN_14 |->
    lane_w[3][31:18] == chan_val[2] && lane_w[3][17:4] == chan_val[3] &&
    lane_len == 6'h1C)
    else $error("shared lane order wrong");

  a_word_12_drop: assert property ( // [RULE_16]
    rate_hi == RATE_12 && rate_lo == FMT_RATE_12 && pat_sel == PAT_ONES &&
    !shared_lane_mode && !avg_on |-> lane_w[0] == 32'hFFF00000)
    else $error("12 bit word not trimmed");

  a_word_16_pad: assert property ( // [RULE_16]
    rate_hi == RATE_16 && rate_lo == FMT_RATE_STD && pat_sel == PAT_ONES &&
    !shared_lane_mode && !avg_on |-> lane_w[1] == 32'hFFFC0000)
    else $error("16 bit word not padded");

  a_ramp_step: assert property ( // [RULE_18]
    !psync_rise |=> ramp_q == $past(ramp_q) + SAMP_W'(1))
    else $error("ramp did not step by one");

  a_ramp_sync_start: assert property ( // [RULE_24]
    $rose(pat_sync_on) |=> ramp_q == '0 ##1 ramp_q == 14'h0001)
    else $error("ramp did not restart on sync");

  a_toggle_alt: assert property ( // [RULE_22]
    pat_sel == PAT_TOGGLE ##1 pat_sel == PAT_TOGGLE |->
    pat_word == ~$past(pat_word))
    else $error("toggle pattern did not alternate");

  a_custom_value: assert property ( // [RULE_23]
    spi_last && wr_addr == REG_CUST ##2 pat_sel == PAT_CUSTOM |->
    pat_word == $past(wr_data[CUST_HI:0], 2))
    else $error("custom value not presented");

  a_pattern_fixed: assert property ( // [RULE_20]
    pat_sel == PAT_DESKEW && !avg_on && !shared_lane_mode &&
    word_length_select == LEN_14 |-> lane_w[4][31:18] == 14'h1555)
    else $error("deskew word wrong");

  c_shared_mode: cover property (shared_lane_mode && !pat_on && load_w);
  c_avg_mode: cover property (avg_on && !shared_lane_mode && load_w);
  c_ramp_wrap: cover property (pat_sel == PAT_RAMP && ramp_q == 14'h3FFF);
  c_spi_write: cover property (spi_last && mapped(wr_addr));
endmodule

// ==== verification/aop_lane_rx.sv ====
`timescale 1ns/100ps
module aop_lane_rx (
  // Link side
  input wire logic bit_clk_in,
  input wire logic rst_b_in,
  input wire logic frame_in,
  input wire logic [aop_pkg::CH-1:0] rise_in,
  input wire logic [aop_pkg::CH-1:0] fall_in,
  input wire logic [aop_pkg::LEN_W-1:0] len_in,
  // Captured words
  output logic [31:0] word_out [aop_pkg::CH],
  output int count_out
);
  import aop_pkg::*;
  logic [31:0] acc [CH];
  int got;
  logic busy;
  // Rise bit is the earlier, more significant bit of each pair
  always @(posedge bit_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy <= 1'b0;
      got <= 0;
      count_out <= 0;
    end else if (frame_in) begin
      busy <= 1'b1;
      got <= 0;
      for (int l = 0; l < CH; l++) begin
        acc[l] <= 32'h0;
      end
    end else if (busy) begin
      for (int l = 0; l < CH; l++) begin
        acc[l] <= {acc[l][29:0], rise_in[l], fall_in[l]};
      end
      got <= got + 2;
      if (got + 2 >= int'(len_in)) begin
        busy <= 1'b0;
        count_out <= count_out + 1;
        for (int l = 0; l < CH; l++) begin
          word_out[l] <= {acc[l][29:0], rise_in[l], fall_in[l]};
        end
      end
    end
  end
endmodule

// ==== verification/tb_adc_output_digital_processing.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_adc_output_digital_processing;
  import aop_pkg::*;
  logic mclk_in = 0, rst_b_in = 0, sclk_in = 0, sen_b_in = 1;
  logic sdata_in = 0, bit_clk_in = 0, frame, sdout;
  logic [CH*SAMP_W-1:0] adc_data_in = '0;
  logic [CH-1:0] rise, fall;
  logic [LEN_W-1:0] rx_len = LEN_14;
  logic [31:0] rx_word [CH];
  logic [31:0] ew;
  logic [2:0] psel [5];
  int rx_count, num_errors = 0, checks_done = 0;
  int k, g, v;
  real r;
  logic [15:0] rd_word;
  int samp[CH], offs[CH], c[CH], expw[CH], pexp[5];

  initial forever #50 mclk_in = ~mclk_in;
  initial begin
    #13;
    forever #32 bit_clk_in = ~bit_clk_in;
  end

  aop_top i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .sclk_in(sclk_in),
    .sen_b_in(sen_b_in), .sdata_in(sdata_in), .sdout_out(sdout),
    .adc_data_in(adc_data_in), .bit_clk_in(bit_clk_in),
    .lane_rise_out(rise), .lane_fall_out(fall), .frame_out(frame));
  aop_lane_rx i_rx (.bit_clk_in(bit_clk_in), .rst_b_in(rst_b_in),
    .frame_in(frame), .rise_in(rise), .fall_in(fall), .len_in(rx_len),
    .word_out(rx_word), .count_out(rx_count));

  task automatic spi_wr(input logic [7:0] a, input logic [15:0] d);
    logic [23:0] f;
    f = {a, d};
    sen_b_in = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdata_in = f[i];
      repeat (4) @(negedge mclk_in);
      sclk_in = 1'b1;
      repeat (4) @(negedge mclk_in);
      if (i >= 1 && i <= 16) rd_word[i-1] = sdout;
      sclk_in = 1'b0;
    end
    repeat (4) @(negedge mclk_in);
    sen_b_in = 1'b1;
    repeat (8) @(negedge mclk_in);
  endtask

  // Let a few whole words pass so the new settings are in the stream
  task automatic settle(input int len);
    int c0;
    rx_len = LEN_W'(len);
    c0 = rx_count;
    for (int t = 0; t < 400 && rx_count < c0 + 3; t++) @(negedge mclk_in);
    `CHK("word count", 1'b1, rx_count >= c0 + 3)
  endtask

  task automatic cmp_lanes(input int len);
    for (int l = 0; l < CH; l++) begin
      ew = 32'(expw[l]) & ((32'h1 << len) - 32'h1);
      `CHK("lane word", ew, rx_word[l])
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk_in);
    num_errors++;
    close_out();
  end

  initial begin
    void'($urandom(32'h4256));
    repeat (8) @(negedge mclk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    psel = '{PAT_SYNC, PAT_DESKEW, PAT_ZEROS, PAT_ONES, PAT_CUSTOM};
    pexp = '{SYNC_WORD, DESKEW_WORD, 0, 32'h3FFF, $urandom_range(16383)};
    spi_wr(REG_CUST, 16'(pexp[4]));
    for (int p = 0; p < 5; p++) begin
      spi_wr(REG_AVG_PAT, {psel[p], 13'h0000});
      settle(14);
      expw = '{default: pexp[p]};
      cmp_lanes(14);
    end
    // Rewrite the custom value while it is shown, reading the old one back
    spi_wr(REG_CUST, 16'h0000);
    `CHK("readback", 16'(pexp[4]), rd_word)
    spi_wr(REG_AVG_PAT, {PAT_TOGGLE, 13'h0000});
    settle(14);
    `CHK("toggle", 1'b1, rx_word[0][13:0] inside {14'h0000, 14'h3FFF})
    spi_wr(REG_AVG_PAT, {PAT_RAMP, 13'h0000});
    spi_wr(REG_PSYNC, 16'h0100);
    settle(14);
    for (int l = 1; l < CH; l++) begin
      `CHK("ramp", rx_word[0], rx_word[l])
    end
    // Word length on the all-ones word
    spi_wr(REG_AVG_PAT, {PAT_ONES, 13'h0000});
    spi_wr(REG_FMT, 16'h0002);
    spi_wr(REG_OGW, 16'h6000);
    settle(12);
    expw = '{default: 32'h0FFF};
    cmp_lanes(12);
    spi_wr(REG_FMT, 16'h0000);
    spi_wr(REG_OGW, 16'h2000);
    settle(16);
    expw = '{default: 32'hFFFC};
    cmp_lanes(16);
    spi_wr(REG_AVG_PAT, 16'h0000);
    // Offset then format on live samples
    for (int l = 0; l < CH; l++) begin
      samp[l] = int'($urandom_range(8191)) - 4096;
      offs[l] = int'($urandom_range(1023)) - 512;
      c[l] = samp[l] - offs[l];
      spi_wr(CHAN_REG[l], {6'h00, 10'(offs[l])});
      adc_data_in[l*SAMP_W +: SAMP_W] = SAMP_W'(samp[l]);
    end
    spi_wr(REG_OGW, 16'h0100);
    spi_wr(REG_FMT, 16'h0008);
    settle(14);
    for (int l = 0; l < CH; l++) expw[l] = (c[l] & 32'h3FFF) ^ 32'h2000;
    cmp_lanes(14);
    spi_wr(REG_FMT, 16'h0000);
    spi_wr(REG_AVG_PAT, 16'h0800);
    settle(14);
    expw = '{default: 0};
    for (int j = 0; j < 4; j++) expw[j+2] = (c[2*j] + c[2*j+1]) >>> 1;
    cmp_lanes(14);
    spi_wr(REG_AVG_PAT, 16'h0000);
    spi_wr(REG_RATE, 16'h4000);
    settle(28);
    for (int j = 0; j < 4; j++) begin
      expw[j+2] = ((c[2*j] & 32'h3FFF) << 14) | (c[2*j+1] & 32'h3FFF);
    end
    cmp_lanes(28);
    spi_wr(REG_RATE, 16'h0000);
    // Highpass on the low group only, then a step on its samples
    k = 2 + int'($urandom_range(1));
    spi_wr(REG_HPF_LO, 16'(2 * k + 1));
    for (int l = 0; l < 4; l++) begin
      adc_data_in[l*SAMP_W +: SAMP_W] = SAMP_W'($urandom);
    end
    repeat (100) @(negedge mclk_in);
    settle(14);
    for (int l = 0; l < CH; l++) begin
      v = int'(signed'(rx_word[l][13:0]));
      if (l < 4) begin
        `CHK("highpass", 1'b1, v * v <= (1 << (2 * k)))
      end else begin
        `CHK("lane word", SAMP_W'(c[l]), rx_word[l][13:0])
      end
    end
    // Gain after offset on the high group
    for (int l = 4; l < CH; l++) begin
      g = int'($urandom_range(31));
      spi_wr(CHAN_REG[l], {5'(g), 1'b0, 10'(offs[l])});
      r = c[l] * 10.0 ** (0.01 * ((g > 30) ? 30 : g));
      expw[l] = (r > 8191.0) ? 8191 : (r < -8192.0) ? -8192 : int'(r);
    end
    spi_wr(REG_OGW, 16'h1100);
    settle(14);
    for (int l = 4; l < CH; l++) begin
      v = int'(signed'(rx_word[l][13:0])) - expw[l];
      `CHK("gain", 1'b1, v >= -4 && v <= 4)
    end
    close_out();
  end
endmodule
